// file: hdl/sat_tx.v
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`include "sat_defs.vh"
module sat_tx (
  // APB clock, reset and slave port.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  // Serial bit clock pin.
  input wire sclk_in,
  output wire sclk_out,
  output wire sclk_oe_n,
  // Word select pin.
  input wire ws_in,
  output wire ws_out,
  output wire ws_oe_n,
  // Serial data out pin.
  output wire sd_out,
  output wire sd_oe_n,
  // Service request for interrupt controller and DMA.
  output wire tx_service_req,
  // Shared with the receive channel.
  output wire [`SAT_CFG_W-1:0] rx_cfg,
  output wire rx_enable,
  output wire link_sample_pulse,
  output wire link_ws
);

  // Software-visible state.
  reg [`SAT_CFG_W-1:0] tx_cfg_ff; // Transmit options.
  reg [`SAT_CFG_W-1:0] rx_cfg_ff; // Receive options.
  reg tx_en_ff; // Transmitter enable.
  reg rx_en_ff; // Receiver enable.
  reg [4:0] limit_ff; // Service request limit.
  // APB answer registers.
  reg ack_ff; // High in the second access cycle.
  reg [31:0] rdata_ff; // Registered read data.
  reg err_ff; // Registered error answer.
  // Dual-mode half pair.
  reg half_ff; // A left sample waits for its partner.
  reg [31:0] half_l_ff; // That left sample.
  // Clock generator and link edge detection.
  reg [7:0] div_ff; // Half-period counter.
  reg sclk_gen_ff; // Generated bit clock, before inversion.
  reg sclk_prev_ff; // Last seen slave clock level.
  reg ws_cap_ff; // Slave word select caught at sample edge.
  reg [5:0] bcnt_ff; // Master bit position in slot.
  reg ws_gen_ff; // Generated word select.
  // Serializer.
  reg ws_last_ff; // Channel of the running slot.
  reg pend_ff; // Standard format: start delayed one bit.
  reg [31:0] sh_ff; // Output shift register.
  reg [31:0] cur_r_ff; // Right sample of the running pair.
  reg [31:0] last_l_ff; // Last left sample sent.
  reg [31:0] last_r_ff; // Last right sample sent.
  reg started_ff; // First slot has begun since enable.

  // Decoded options.
  wire [1:0] fmt = tx_cfg_ff[`SAT_CFG_FMT_LSB+1:`SAT_CFG_FMT_LSB];
  wire inv = tx_cfg_ff[`SAT_CFG_INV_BIT];
  wire [1:0] mode = tx_cfg_ff[`SAT_CFG_MODE_LSB+1:`SAT_CFG_MODE_LSB];
  wire master = tx_cfg_ff[`SAT_CFG_MASTER_BIT];
  wire [2:0] ssz = tx_cfg_ff[`SAT_CFG_SSZ_LSB+2:`SAT_CFG_SSZ_LSB];
  wire [2:0] wsz = tx_cfg_ff[`SAT_CFG_WSZ_LSB+2:`SAT_CFG_WSZ_LSB];
  wire repeat_last = tx_cfg_ff[`SAT_CFG_REPEAT_BIT];

  // Width in bits for a size code; unknown codes fall back to 32.
  function [5:0] sz_bits;
    input [2:0] code;
    begin
      case (code)
        `SAT_SZ_24: sz_bits = 6'd24;
        `SAT_SZ_20: sz_bits = 6'd20;
        `SAT_SZ_16: sz_bits = 6'd16;
        `SAT_SZ_8: sz_bits = 6'd8;
        default: sz_bits = 6'd32;
      endcase
    end
  endfunction

  // Compact modes fix the sample width by their packing.
  wire [5:0] s_bits = (mode == `SAT_MODE_C16) ? 6'd16 :
    (mode == `SAT_MODE_C8) ? 6'd8 : sz_bits(ssz);
  wire [5:0] w_bits = sz_bits(wsz);

  // APB decode. Every access takes one wait cycle so that read data
  // and the error answer come straight from flip-flops.
  wire acc = psel & penable;
  wire done = acc & ack_ff;
  wire wr = done & pwrite;
  wire known = (paddr == `SAT_OFS_TXDATA) | (paddr == `SAT_OFS_TXCFG) |
    (paddr == `SAT_OFS_RXCFG) | (paddr == `SAT_OFS_TXRXCFG) |
    (paddr == `SAT_OFS_CTRL) | (paddr == `SAT_OFS_LIMIT) |
    (paddr == `SAT_OFS_STATUS);

  // Store and level accounting.
  wire [63:0] f_rdata;
  wire [3:0] f_count;
  wire f_full;
  wire f_empty;
  reg f_push;
  reg [63:0] f_wdata;
  wire f_pop;
  wire [4:0] level = {f_count, half_ff};
  wire room = ~f_full;

  // Service request: level strictly below the limit; zero never fires.
  assign tx_service_req = (level < limit_ff);

  // Data written to the store, unpacked per mode.
  always @* begin
    f_push = 1'b0;
    f_wdata = 64'h0;
    if (wr && (paddr == `SAT_OFS_TXDATA) && room) begin
      case (mode)
        `SAT_MODE_DUAL: begin
          // Right partner completes the pair started by the left.
          f_push = half_ff;
          f_wdata = {pwdata, half_l_ff};
        end
        `SAT_MODE_C16: begin
          f_push = 1'b1;
          f_wdata = {16'h0, pwdata[31:16], 16'h0, pwdata[15:0]};
        end
        `SAT_MODE_C8: begin
          // Upper half of the word is ignored.
          f_push = 1'b1;
          f_wdata = {24'h0, pwdata[15:8], 24'h0, pwdata[7:0]};
        end
        default: begin
          // Mono: one sample stands for a whole pair.
          f_push = 1'b1;
          f_wdata = {pwdata, pwdata};
        end
      endcase
    end
  end

  sat_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(f_push),
    .wdata(f_wdata),
    .pop(f_pop),
    .rdata(f_rdata),
    .count(f_count),
    .full(f_full),
    .empty(f_empty)
  );

  // APB register writes and answers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cfg_ff <= `SAT_CFG_RST;
      rx_cfg_ff <= `SAT_CFG_RST;
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      limit_ff <= `SAT_LIMIT_RST;
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0;
      err_ff <= 1'b0;
      half_ff <= 1'b0;
      half_l_ff <= 32'h0;
    end else begin
      ack_ff <= acc & ~ack_ff;
      if (acc && !ack_ff) begin
        err_ff <= ~known;
        rdata_ff <= 32'h0;
        case (paddr)
          `SAT_OFS_TXCFG: rdata_ff <= {19'h0, tx_cfg_ff};
          `SAT_OFS_RXCFG: rdata_ff <= {19'h0, rx_cfg_ff};
          `SAT_OFS_CTRL: rdata_ff <= {30'h0, rx_en_ff, tx_en_ff};
          `SAT_OFS_LIMIT: rdata_ff <= {27'h0, limit_ff};
          `SAT_OFS_STATUS: rdata_ff <= {22'h0, tx_service_req, room,
            3'h0, level};
          default: rdata_ff <= 32'h0;
        endcase
      end
      if (wr) begin
        case (paddr)
          `SAT_OFS_TXCFG: tx_cfg_ff <= pwdata[`SAT_CFG_W-1:0];
          `SAT_OFS_RXCFG: rx_cfg_ff <= pwdata[`SAT_CFG_W-1:0];
          `SAT_OFS_TXRXCFG: begin
            // One write gives both channels the same options.
            tx_cfg_ff <= pwdata[`SAT_CFG_W-1:0];
            rx_cfg_ff <= pwdata[`SAT_CFG_W-1:0];
          end
          `SAT_OFS_CTRL: begin
            tx_en_ff <= pwdata[`SAT_CTRL_TXEN_BIT];
            rx_en_ff <= pwdata[`SAT_CTRL_RXEN_BIT];
          end
          // Odd limits are rounded down so the limit stays even.
          `SAT_OFS_LIMIT: limit_ff <= (pwdata[4:0] > `SAT_LEVEL_MAX) ?
            `SAT_LEVEL_MAX : {pwdata[4:1], 1'b0};
          default: begin
          end
        endcase
      end
      // Dual mode: a left write parks, the right write completes it.
      if (wr && (paddr == `SAT_OFS_TXDATA) && room &&
          (mode == `SAT_MODE_DUAL)) begin
        half_ff <= ~half_ff;
        half_l_ff <= pwdata;
      end
    end
  end

  assign pready = done;
  assign prdata = rdata_ff;
  assign pslverr = done & err_ff;

  // Slave clocks are synchronised before any use.
  wire sclk_s;
  wire ws_s;
  sat_sync u_sync_sclk (
    .pclk(pclk),
    .presetn(presetn),
    .din(sclk_in),
    .dout(sclk_s)
  );
  sat_sync u_sync_ws (
    .pclk(pclk),
    .presetn(presetn),
    .din(ws_in),
    .dout(ws_s)
  );

  // Link edges. The effective clock is uninverted so that data always
  // changes on its fall and is sampled on its rise.
  wire any_en = tx_en_ff | rx_en_ff;
  wire half_tick = (div_ff == (`SAT_SCLK_HALF_CYC - 1));
  wire s_eff = sclk_s ^ inv;
  wire s_rise = s_eff & ~(sclk_prev_ff ^ inv);
  wire s_fall = ~s_eff & (sclk_prev_ff ^ inv);
  wire m_rise = half_tick & ~sclk_gen_ff;
  wire m_fall = half_tick & sclk_gen_ff;
  wire shift_ev = tx_en_ff & (master ? m_fall : s_fall);
  wire samp_ev = any_en & (master ? m_rise : s_rise);

  // Master select leads by one shift edge; a slave reads the pin, synchronised like its clock.
  wire ws_wrap = (bcnt_ff == (w_bits - 6'd1));
  wire ws_nxt = ws_wrap ? ~ws_gen_ff : ws_gen_ff;
  wire ws_cur = master ? ws_nxt : ws_s;

  // Clock generator. It restarts while both channels are idle, so a
  // joint enable launches both channels on one common set of clocks.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 8'h0;
      sclk_gen_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
      ws_cap_ff <= 1'b0;
      bcnt_ff <= 6'h0;
      ws_gen_ff <= 1'b1;
    end else begin
      sclk_prev_ff <= sclk_s;
      if (!any_en || !master) begin
        div_ff <= 8'h0;
        sclk_gen_ff <= 1'b0;
        bcnt_ff <= w_bits - 6'd1; // Parked on a right slot's last bit.
        ws_gen_ff <= 1'b1; // So the first fall opens a full left slot.
      end else if (half_tick) begin
        div_ff <= 8'h0;
        sclk_gen_ff <= ~sclk_gen_ff;
        if (sclk_gen_ff) begin
          // Falling edge: step the slot position, flip at its end.
          bcnt_ff <= ws_wrap ? 6'h0 : bcnt_ff + 6'h1;
          ws_gen_ff <= ws_nxt;
        end
      end else begin
        div_ff <= div_ff + 8'h1;
      end
      if (!master && s_rise) begin
        ws_cap_ff <= ws_s;
      end
    end
  end

  // Shared timing for the receive channel.
  assign link_sample_pulse = samp_ev;
  assign link_ws = master ? ws_gen_ff : ws_cap_ff;
  assign rx_cfg = rx_cfg_ff;
  assign rx_enable = rx_en_ff;

  // Slot start: a left slot takes the next pair from the store.
  wire slot_go = shift_ev & ((ws_cur != ws_last_ff) ?
    (fmt != `SAT_FMT_STD) : pend_ff);
  wire take_l = slot_go & ~ws_cur;
  assign f_pop = take_l & ~f_empty;

  // Sample chosen for this slot; empty store sends zero or repeats.
  reg [31:0] smp;
  always @* begin
    smp = 32'h0;
    if (ws_cur) begin
      smp = cur_r_ff;
    end else if (!f_empty) begin
      smp = f_rdata[31:0];
    end else if (repeat_last) begin
      smp = last_l_ff;
    end
  end

  // Align the sample inside the wire word, most significant bit first.
  // Right-justified ends on the last wire bit; the other formats start
  // on the first. Bits beyond the wire width are simply not sent.
  wire [31:0] masked = smp & ~(32'hffffffff << s_bits);
  wire [5:0] lsh = (fmt == `SAT_FMT_RIGHT) ? (6'd32 - w_bits) :
    (6'd32 - s_bits);
  wire [31:0] aligned = masked << lsh;

  // Serializer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_last_ff <= 1'b1;
      pend_ff <= 1'b0;
      sh_ff <= 32'h0;
      cur_r_ff <= 32'h0;
      last_l_ff <= 32'h0;
      last_r_ff <= 32'h0;
      started_ff <= 1'b0;
    end else if (!tx_en_ff) begin
      // Disabled: idle so the next frame starts on a left slot.
      ws_last_ff <= 1'b1;
      pend_ff <= 1'b0;
      sh_ff <= 32'h0;
      started_ff <= 1'b0;
    end else if (shift_ev) begin
      if (ws_cur != ws_last_ff) begin
        ws_last_ff <= ws_cur;
        // Standard framing starts data one bit after the select flips.
        pend_ff <= (fmt == `SAT_FMT_STD);
      end else begin
        pend_ff <= 1'b0;
      end
      if (slot_go) begin
        sh_ff <= aligned;
        started_ff <= 1'b1;
        if (take_l) begin
          if (!f_empty) begin
            cur_r_ff <= f_rdata[63:32];
            last_l_ff <= f_rdata[31:0];
            last_r_ff <= f_rdata[63:32];
          end else begin
            cur_r_ff <= repeat_last ? last_r_ff : 32'h0;
          end
        end
      end else begin
        sh_ff <= {sh_ff[30:0], 1'b0};
      end
    end
  end

  // Pins. Enables are active low; nothing is driven while disabled,
  // and a slave never drives the clocks.
  assign sclk_out = sclk_gen_ff ^ inv;
  assign ws_out = ws_gen_ff;
  assign sclk_oe_n = ~(tx_en_ff & master);
  assign ws_oe_n = ~(tx_en_ff & master);
  assign sd_out = sh_ff[31] & started_ff;
  assign sd_oe_n = ~tx_en_ff;

endmodule // sat_tx

// file: hdl/sat_defs.vh
`ifndef SAT_DEFS_VH
`define SAT_DEFS_VH

// Register byte offsets on the APB bus.
`define SAT_OFS_TXDATA 12'h000
`define SAT_OFS_TXCFG 12'h004
`define SAT_OFS_RXCFG 12'h008
`define SAT_OFS_TXRXCFG 12'h00c
`define SAT_OFS_CTRL 12'h010
`define SAT_OFS_LIMIT 12'h014
`define SAT_OFS_STATUS 12'h018

// Configuration word fields.
`define SAT_CFG_FMT_LSB 0
`define SAT_CFG_INV_BIT 2
`define SAT_CFG_MODE_LSB 3
`define SAT_CFG_MASTER_BIT 5
`define SAT_CFG_SSZ_LSB 6
`define SAT_CFG_WSZ_LSB 9
`define SAT_CFG_REPEAT_BIT 12
`define SAT_CFG_W 13
`define SAT_CFG_RST 13'h0000

// Frame formats.
`define SAT_FMT_STD 2'h0
`define SAT_FMT_LEFT 2'h1
`define SAT_FMT_RIGHT 2'h2

// Channel modes.
`define SAT_MODE_DUAL 2'h0
`define SAT_MODE_C16 2'h1
`define SAT_MODE_C8 2'h2
`define SAT_MODE_MONO 2'h3

// Size codes for sample and wire width.
`define SAT_SZ_32 3'h0
`define SAT_SZ_24 3'h1
`define SAT_SZ_20 3'h2
`define SAT_SZ_16 3'h3
`define SAT_SZ_8 3'h4

// Control fields.
`define SAT_CTRL_TXEN_BIT 0
`define SAT_CTRL_RXEN_BIT 1

// Status fields.
`define SAT_ST_LEVEL_LSB 0
`define SAT_ST_ROOM_BIT 8
`define SAT_ST_REQ_BIT 9

// Reset values and sizes.
`define SAT_LIMIT_RST 5'h00
`define SAT_LEVEL_MAX 5'h10
`define SAT_PAIRS 8

// Master bit clock: half period in ns and derived pclk cycles.
`define SAT_PCLK_NS 4
`define SAT_SCLK_HALF_NS 32
`define SAT_SCLK_HALF_CYC (`SAT_SCLK_HALF_NS / `SAT_PCLK_NS)

`endif

// file: hdl/sat_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for one level that comes from outside pclk.
module sat_sync (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Asynchronous level in, synchronised level out.
  input wire din,
  output wire dout
);

  reg meta_ff; // First stage, read only by the second stage.
  reg sync_ff; // Second stage, safe to use.

  // Plain two-flop chain; reset to a known low level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule // sat_sync

// file: hdl/sat_fifo.v
`timescale 1ns/100ps
`include "sat_defs.vh"
// Sample-pair store: each entry holds a left and a right sample.
module sat_fifo (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Fill side.
  input wire push,
  input wire [63:0] wdata,
  // Drain side.
  input wire pop,
  output wire [63:0] rdata,
  // Occupancy.
  output wire [3:0] count,
  output wire full,
  output wire empty
);

  reg [63:0] mem_ff [0:`SAT_PAIRS-1]; // Pair storage.
  reg [2:0] wptr_ff; // Next slot to fill.
  reg [2:0] rptr_ff; // Oldest slot.
  reg [3:0] cnt_ff; // Pairs held.
  wire do_push; // Push that really lands.
  wire do_pop; // Pop that really takes.

  // A full store refuses pushes and an empty one refuses pops.
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  // Pointers and occupancy count.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_ff <= 3'h0;
      rptr_ff <= 3'h0;
      cnt_ff <= 4'h0;
    end else begin
      if (do_push) begin
        wptr_ff <= wptr_ff + 3'h1;
      end
      if (do_pop) begin
        rptr_ff <= rptr_ff + 3'h1;
      end
      cnt_ff <= cnt_ff + {3'h0, do_push} - {3'h0, do_pop};
    end
  end

  // Storage has no reset; nothing reads a slot before it is written.
  always @(posedge pclk) begin
    if (do_push) begin
      mem_ff[wptr_ff] <= wdata;
    end
  end

  assign rdata = mem_ff[rptr_ff];
  assign count = cnt_ff;
  assign full = (cnt_ff == 4'h8);
  assign empty = (cnt_ff == 4'h0);

endmodule // sat_fifo

// file: test/sat_tx_chk.sv
`timescale 1ns/100ps
`include "sat_defs.vh"
// Watches the APB side and the link pin enables of the transmitter.
module sat_tx_chk (
  // Clock, reset and APB.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  // Link pins and side outputs.
  input wire sclk_out,
  input wire sclk_oe_n,
  input wire ws_oe_n,
  input wire sd_oe_n,
  input wire tx_service_req,
  input wire [`SAT_CFG_W-1:0] rx_cfg
);
  // Transfers that complete at this edge.
  wire wr_done = psel && penable && pready && pwrite;
  wire rd_done = psel && penable && pready && !pwrite;
  logic [4:0] lim_ff; // Limit as software set it, clamped and made even.
  logic en_ff; // Transmit enable as last written.
  logic [`SAT_CFG_W-1:0] cfg_ff; // Transmit configuration as last written.
  wire run = en_ff && cfg_ff[`SAT_CFG_MASTER_BIT]; // Master clock should be running.
  // Mirror of the registers; only completed writes count.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lim_ff <= `SAT_LIMIT_RST;
      en_ff <= 1'b0;
      cfg_ff <= `SAT_CFG_RST;
    end else if (wr_done) begin
      if (paddr == `SAT_OFS_LIMIT) begin
        lim_ff <= (pwdata[4:0] > 5'h10) ? 5'h10 : {pwdata[4:1], 1'b0};
      end
      if (paddr == `SAT_OFS_CTRL) begin
        en_ff <= pwdata[`SAT_CTRL_TXEN_BIT];
      end
      if (paddr == `SAT_OFS_TXCFG || paddr == `SAT_OFS_TXRXCFG) begin
        cfg_ff <= pwdata[`SAT_CFG_W-1:0];
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Half a bit period is eight clocks of stable level, then a change.
  sequence s_half;
    $stable(sclk_out)[*7] ##1 $changed(sclk_out);
  endsequence
  sequence s_st_read;
    rd_done && paddr == `SAT_OFS_STATUS;
  endsequence
  a_req_below_limit: assert property (s_st_read |->
    prdata[`SAT_ST_REQ_BIT] == (prdata[4:0] < lim_ff)) else $error("request flag wrong");
  a_req_zero_off: assert property (lim_ff == 5'h00 |-> !tx_service_req)
    else $error("request while limit is zero");
  a_level_room: assert property (s_st_read |-> prdata[4:0] <= `SAT_LEVEL_MAX &&
    prdata[`SAT_ST_ROOM_BIT] == (prdata[4:0] != `SAT_LEVEL_MAX)) else $error("level or room bad");
  a_limit_back: assert property (rd_done && paddr == `SAT_OFS_LIMIT |->
    prdata[4:0] == lim_ff) else $error("limit readback wrong");
  a_idle_quiet: assert property (!en_ff && !$past(en_ff) |->
    sd_oe_n && sclk_oe_n && ws_oe_n) else $error("pins driven while disabled");
  a_data_driven: assert property (en_ff && $past(en_ff) |-> !sd_oe_n)
    else $error("data not driven while enabled");
  a_clock_role: assert property (en_ff && $past(en_ff) |->
    sclk_oe_n == !cfg_ff[`SAT_CFG_MASTER_BIT] && ws_oe_n == sclk_oe_n)
    else $error("clock drive does not match role");
  a_sclk_half: assert property (run && $changed(sclk_out) |=>
    s_half or (##[0:7] !run)) else $error("bit clock half period wrong");
  a_rx_cfg_copy: assert property (wr_done && paddr == `SAT_OFS_TXRXCFG |=>
    rx_cfg == cfg_ff) else $error("receive config not shared");
endmodule // sat_tx_chk
bind sat_tx sat_tx_chk u_chk (.*);

// file: test/sat_codec.sv
`timescale 1ns/100ps
// Behavioural codec on the far side of the serial link.
module sat_codec (
  // Wire levels seen on the link.
  input wire sclk,
  input wire ws,
  input wire sd,
  // Bench controls: clock making and edge polarity.
  input wire gen_on,
  input wire inv,
  // Clocks made here when the transmitter is a slave.
  output logic sclk_gen,
  output logic ws_gen,
  // Last bits heard in each slot.
  output logic [31:0] left_word,
  output logic [31:0] right_word
);
  int bit_cnt = 0; // Bits since the last word select flip.
  initial begin
    sclk_gen = 1'b0;
    ws_gen = 1'b1;
    left_word = 32'h0;
    right_word = 32'h0;
  end
  // 64 ns bit clock that stands still while gen_on is low; word select flips on an
  // effective falling edge so it never moves under a sampling edge.
  always begin
    #32;
    if (gen_on) begin
      sclk_gen = ~sclk_gen;
      if ((sclk_gen ^ inv) == 1'b0) begin
        bit_cnt++;
        if (bit_cnt == 16) begin
          bit_cnt = 0;
          ws_gen = ~ws_gen;
        end
      end
    end
  end
  // Sample on the effective rising edge, MSB first, into the slot's word.
  always @(posedge (sclk ^ inv)) begin
    if (ws) right_word <= {right_word[30:0], sd};
    else left_word <= {left_word[30:0], sd};
  end
endmodule // sat_codec

// file: test/sat_tx_bench.sv
`timescale 1ns/100ps
`include "sat_defs.vh"
// Self-checking bench: APB master, codec model and one task per scenario.
module sat_tx_bench;
  logic pclk = 1'b0; // APB master side.
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic sclk_out, sclk_oe_n, ws_out, ws_oe_n, sd_out, sd_oe_n, req; // Link pins.
  logic gen_on = 1'b0; // Codec controls.
  logic inv = 1'b0;
  logic sclk_gen, ws_gen;
  logic rxe, pulse; // Receive enable and shared sample pulse.
  logic [31:0] lw, rw;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  // The codec drives the clock and select lines that the transmitter lets go.
  wire sclk_w = sclk_oe_n ? sclk_gen : sclk_out;
  wire ws_w = ws_oe_n ? ws_gen : ws_out;
  wire sd_w = sd_oe_n ? ~sd_out : sd_out; // Released data shows a changed level.
  sat_tx dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .ws_in(ws_w),
    .ws_out(ws_out), .ws_oe_n(ws_oe_n), .sd_out(sd_out), .sd_oe_n(sd_oe_n),
    .tx_service_req(req), .rx_cfg(), .rx_enable(rxe), .link_sample_pulse(pulse), .link_ws()
  );
  sat_codec codec (
    .sclk(sclk_w), .ws(ws_w), .sd(sd_w), .gen_on(gen_on), .inv(inv),
    .sclk_gen(sclk_gen), .ws_gen(ws_gen), .left_word(lw), .right_word(rw)
  );
  // 250 MHz clock.
  initial begin
    forever #2 pclk = ~pclk;
  end
  // The scenarios need about 6700 cycles; a hang ends the run here.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("Error at %0t: timeout after %h cycles", $time, cyc);
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer, entered just after an edge; the request holds until pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Waits for a left and a right slot and compares the bits heard.
  task automatic frame(input logic [15:0] l, input logic [15:0] r, input logic [15:0] m);
    @(posedge ws_w);
    chk({16'h0, lw[15:0] & m}, {16'h0, l & m});
    @(negedge ws_w);
    chk({16'h0, rw[15:0] & m}, {16'h0, r & m});
    @(posedge pclk);
  endtask
  task automatic t_regs;
    rdc(`SAT_OFS_STATUS, 32'h100);
    rdc(`SAT_OFS_LIMIT, 32'h0);
    wr(`SAT_OFS_LIMIT, 32'h8);
    rdc(`SAT_OFS_LIMIT, 32'h8);
    wr(`SAT_OFS_LIMIT, 32'h7);
    rdc(`SAT_OFS_LIMIT, 32'h6);
    wr(`SAT_OFS_TXRXCFG, 32'h1abc);
    rdc(`SAT_OFS_TXCFG, 32'h1abc);
    rdc(`SAT_OFS_RXCFG, 32'h1abc);
    wr(`SAT_OFS_CTRL, 32'h2);
    @(posedge pulse);
    chk({31'h0, rxe}, 32'h1);
    @(posedge pclk);
    wr(`SAT_OFS_CTRL, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("t_regs done");
  endtask
  // Filling while disabled: mono, compact and dual writes, then a full store.
  task automatic t_level;
    wr(`SAT_OFS_TXCFG, 32'h18);
    wr(`SAT_OFS_TXDATA, 32'ha55a);
    rdc(`SAT_OFS_STATUS, 32'h302);
    chk({31'h0, req}, 32'h1);
    wr(`SAT_OFS_TXCFG, 32'h08);
    wr(`SAT_OFS_TXDATA, 32'hb00bc00c);
    rdc(`SAT_OFS_STATUS, 32'h304);
    wr(`SAT_OFS_TXCFG, 32'h00);
    wr(`SAT_OFS_TXDATA, 32'h1111);
    rdc(`SAT_OFS_STATUS, 32'h305);
    wr(`SAT_OFS_TXDATA, 32'h2222);
    rdc(`SAT_OFS_STATUS, 32'h106);
    chk({31'h0, req}, 32'h0);
    wr(`SAT_OFS_LIMIT, 32'h10);
    rdc(`SAT_OFS_STATUS, 32'h306);
    for (int i = 0; i < 5; i++) begin
      wr(`SAT_OFS_TXDATA, 32'h3000 + i);
      wr(`SAT_OFS_TXDATA, 32'h4000 + i);
    end
    wr(`SAT_OFS_TXDATA, 32'hdead);
    rdc(`SAT_OFS_STATUS, 32'h010);
    $display("t_level done");
  endtask
  // Master, left-justified 16 on 16: drain, zeros when empty; then right-justified
  // 8 in 16 with repeats when empty.
  task automatic t_master;
    wr(`SAT_OFS_TXCFG, 32'h6e1);
    wr(`SAT_OFS_CTRL, 32'h1);
    @(negedge ws_w);
    frame(16'ha55a, 16'ha55a, 16'hffff);
    frame(16'hc00c, 16'hb00b, 16'hffff);
    frame(16'h1111, 16'h2222, 16'hffff);
    for (int i = 0; i < 5; i++) begin
      frame(16'h3000 + i[15:0], 16'h4000 + i[15:0], 16'hffff);
    end
    frame(16'h0, 16'h0, 16'hffff);
    rdc(`SAT_OFS_STATUS, 32'h300);
    wr(`SAT_OFS_CTRL, 32'h0);
    chk({29'h0, sd_oe_n, sclk_oe_n, ws_oe_n}, 32'h7);
    wr(`SAT_OFS_TXCFG, 32'h1722);
    wr(`SAT_OFS_TXDATA, 32'h5555);
    wr(`SAT_OFS_TXDATA, 32'h6666);
    wr(`SAT_OFS_CTRL, 32'h1);
    @(negedge ws_w);
    frame(16'h0055, 16'h0066, 16'hffff);
    frame(16'h0055, 16'h0066, 16'hffff);
    wr(`SAT_OFS_CTRL, 32'h0);
    $display("t_master done");
  endtask
  // Slave on codec clocks, standard framing, inverted clock, compact 8 in 16.
  task automatic t_slave;
    wr(`SAT_OFS_TXCFG, 32'h614);
    wr(`SAT_OFS_TXDATA, 32'hffffa53c);
    wr(`SAT_OFS_TXDATA, 32'hffffa53c);
    inv <= 1'b1;
    gen_on <= 1'b1;
    wr(`SAT_OFS_CTRL, 32'h1);
    @(negedge ws_w);
    frame(16'h1e00, 16'h5280, 16'h7f80);
    wr(`SAT_OFS_CTRL, 32'h0);
    gen_on <= 1'b0;
    $display("t_slave done");
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_level;
    t_master;
    t_slave;
    finish_test;
  end
endmodule // sat_tx_bench
